// *** verilog/stc_pkg.sv ***
package stc_pkg;

  // ----------------------------------------------------------------
  // clock and pwm timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int PWM_PERIOD_NS = 50_000;
  localparam int PWM_PERIOD_CYCLES = (PWM_PERIOD_NS / 1000) * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COIL_X = 8'h0C;
  localparam logic [7:0] ADDR_COIL_Y = 8'h10;
  localparam logic [7:0] ADDR_STEPS = 8'h14;

  // control register fields
  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_EN_BIT = 2;
  localparam int CTRL_RES_LSB = 4;
  localparam int CTRL_RES_MSB = 6;

  // status register fields
  localparam int STAT_POS_LSB = 0;
  localparam int STAT_POS_MSB = 6;
  localparam int STAT_DIR_BIT = 8;
  localparam int STAT_RES_LSB = 12;
  localparam int STAT_RES_MSB = 14;
  localparam int STAT_CUR_LSB = 16;
  localparam int STAT_CUR_MSB = 20;

  // coil register fields
  localparam int COIL_MAG_MSB = 15;
  localparam int COIL_NEG_BIT = 31;

  // reset values
  localparam logic [6:0] POS_RESET = 7'h00;
  localparam logic [4:0] CUR_RESET = 5'h00;
  localparam logic [15:0] STEPS_RESET = 16'h0000;
  localparam logic [15:0] STEPS_ONE = 16'h0001;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // step resolution codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RES_1_32 = 3'h0;
  localparam logic [2:0] RES_1_16 = 3'h1;
  localparam logic [2:0] RES_1_8 = 3'h2;
  localparam logic [2:0] RES_1_4 = 3'h3;
  localparam logic [2:0] RES_1_2 = 3'h4;
  localparam logic [2:0] RES_FULL = 3'h5;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } stc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } stc_apb_rsp_t;

  typedef struct packed {
    logic negative;
    logic [15:0] magnitude;
  } stc_coil_t;

  // ----------------------------------------------------------------
  // shared arithmetic
  // ----------------------------------------------------------------
  // table units moved per trigger; unused codes fall back to finest
  function automatic logic [6:0] stc_step_increment(input logic [2:0] res);
    case (res)
      RES_1_32: stc_step_increment = 7'h01;
      RES_1_16: stc_step_increment = 7'h02;
      RES_1_8: stc_step_increment = 7'h04;
      RES_1_4: stc_step_increment = 7'h08;
      RES_1_2: stc_step_increment = 7'h10;
      RES_FULL: stc_step_increment = 7'h20;
      default: stc_step_increment = 7'h01;
    endcase
  endfunction

  // nearest grid point of a power-of-two grid, ties round up, wraps mod 128
  function automatic logic [6:0] stc_snap_nearest(input logic [6:0] pos, input logic [6:0] inc);
    logic [6:0] half;
    half = inc >> 1;
    stc_snap_nearest = (pos + half) & ~(inc - 7'h01);
  endfunction

  // sine magnitude (tenths of percent) scaled by peak current code plus one
  function automatic logic [15:0] stc_scale(input logic [9:0] mag, input logic [4:0] cur);
    logic [5:0] gain;
    gain = {1'b0, cur} + 6'h01;
    stc_scale = mag * gain;
  endfunction

endpackage

// *** verilog/stc_sine_lut.sv ***
`timescale 1ns/10ps
module stc_sine_lut
  import stc_pkg::*;
(
  // table position in 1/32 micro-steps
  input wire logic [6:0] position,
  // coil x follows sine, coil y cosine
  output logic [9:0] x_mag,
  output logic x_neg,
  output logic [9:0] y_mag,
  output logic y_neg
);

  // ----------------------------------------------------------------
  // quarter wave, tenths of percent of peak current
  // ----------------------------------------------------------------
  function automatic logic [9:0] quarter(input logic [5:0] k);
    case (k)
      6'h00: quarter = 10'd0;    6'h01: quarter = 10'd35;   6'h02: quarter = 10'd81;
      6'h03: quarter = 10'd127;  6'h04: quarter = 10'd174;  6'h05: quarter = 10'd221;
      6'h06: quarter = 10'd267;  6'h07: quarter = 10'd314;  6'h08: quarter = 10'd349;
      6'h09: quarter = 10'd383;  6'h0A: quarter = 10'd430;  6'h0B: quarter = 10'd465;
      6'h0C: quarter = 10'd500;  6'h0D: quarter = 10'd546;  6'h0E: quarter = 10'd581;
      6'h0F: quarter = 10'd616;  6'h10: quarter = 10'd651;  6'h11: quarter = 10'd686;
      6'h12: quarter = 10'd721;  6'h13: quarter = 10'd755;  6'h14: quarter = 10'd790;
      6'h15: quarter = 10'd826;  6'h16: quarter = 10'd849;  6'h17: quarter = 10'd872;
      6'h18: quarter = 10'd895;  6'h19: quarter = 10'd918;  6'h1A: quarter = 10'd930;
      6'h1B: quarter = 10'd941;  6'h1C: quarter = 10'd953;  6'h1D: quarter = 10'd965;
      6'h1E: quarter = 10'd977;  6'h1F: quarter = 10'd988;  6'h20: quarter = 10'd1000;
      default: quarter = 10'd0;
    endcase
  endfunction

  function automatic logic [9:0] wave_mag(input logic [6:0] a);
    wave_mag = a[5] ? quarter(6'h20 - {1'b0, a[4:0]}) : quarter({1'b0, a[4:0]});
  endfunction

  wire [6:0] cos_angle = position + 7'h20;

  assign x_mag = wave_mag(position);
  assign x_neg = position[6] & (x_mag != 10'd0);
  assign y_mag = wave_mag(cos_angle);
  assign y_neg = cos_angle[6] & (y_mag != 10'd0);

endmodule

// *** verilog/stc_pwm_timer.sv ***
`timescale 1ns/10ps
module stc_pwm_timer
  import stc_pkg::*;
#(
  parameter int PERIOD_CYCLES = PWM_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // one-cycle pulse at the start of each pwm period
  output logic period_start
);

  logic [15:0] count;
  localparam logic [15:0] LAST = 16'(PERIOD_CYCLES - 1);

  wire wrap = (count == LAST);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 16'h0000;
      period_start <= 1'b0;
    end else begin
      count <= wrap ? 16'h0000 : count + 16'h0001;
      period_start <= wrap;
    end
  end

endmodule

// *** verilog/stc_translator.sv ***
`timescale 1ns/10ps
module stc_translator
  import stc_pkg::*;
#(
  parameter int PWM_CYCLES = PWM_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire stc_apb_req_t apb_req,
  output stc_apb_rsp_t apb_rsp,
  // step and direction pins from the controller
  input wire logic step_trigger_input,
  input wire logic direction_pin,
  // translator state
  output logic [6:0] translator_position,
  output logic step_pulse,
  output logic drivers_enable,
  // coil current targets
  output stc_coil_t coil_x_target,
  output stc_coil_t coil_y_target,
  output logic pwm_period_start
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic step_meta;
  logic step_sync;
  logic step_prev;
  logic dir_meta;
  logic dir_sync;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_meta <= 1'b0;
      step_sync <= 1'b0;
      step_prev <= 1'b0;
      dir_meta <= 1'b0;
      dir_sync <= 1'b0;
    end else begin
      step_meta <= step_trigger_input;
      step_sync <= step_meta;
      step_prev <= step_sync;
      dir_meta <= direction_pin;
      dir_sync <= dir_meta;
    end
  end

  // ----------------------------------------------------------------
  // control state written by software
  // ----------------------------------------------------------------
  logic direction_control_bit;
  logic step_edge_polarity_bit;
  logic [2:0] step_resolution_select;
  logic [4:0] peak_current_setting;
  logic [15:0] step_count;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire access = apb_req.psel & apb_req.penable;
  wire first_access = access & ~apb_rsp.pready;
  wire commit = access & apb_rsp.pready;
  wire write_commit = commit & apb_req.pwrite;

  wire hit_ctrl = (apb_req.paddr == ADDR_CTRL);
  wire hit_current = (apb_req.paddr == ADDR_CURRENT);
  wire hit_status = (apb_req.paddr == ADDR_STATUS);
  wire hit_coil_x = (apb_req.paddr == ADDR_COIL_X);
  wire hit_coil_y = (apb_req.paddr == ADDR_COIL_Y);
  wire hit_steps = (apb_req.paddr == ADDR_STEPS);
  wire mapped = hit_ctrl | hit_current | hit_status | hit_coil_x | hit_coil_y | hit_steps;

  wire wr_ctrl = write_commit & hit_ctrl;
  wire wr_current = write_commit & hit_current;
  wire wr_steps = write_commit & hit_steps;

  // ----------------------------------------------------------------
  // trigger edge and direction
  // ----------------------------------------------------------------
  wire edge_rise = step_sync & ~step_prev;
  wire edge_fall = ~step_sync & step_prev;
  // bit clear: rising edge steps; bit set: falling edge steps
  wire step_accept = step_edge_polarity_bit ? edge_fall : edge_rise;
  // drivers_enable deliberately plays no part in stepping
  wire step_now = step_accept;
  wire step_down = dir_sync ^ direction_control_bit;

  // ----------------------------------------------------------------
  // position arithmetic
  // ----------------------------------------------------------------
  // resolution in force for the last accepted trigger
  logic [2:0] applied_resolution;

  wire [6:0] new_inc = stc_step_increment(step_resolution_select);
  wire [6:0] old_inc = stc_step_increment(applied_resolution);
  wire going_finer = (new_inc < old_inc);
  // an offset carried from an earlier coarse phase is dropped when refining
  wire [6:0] snapped = stc_snap_nearest(translator_position, new_inc);
  // coarser or equal: step from where we stand, offset kept if off grid
  wire [6:0] base_position = going_finer ? snapped : translator_position;
  wire [6:0] position_up = base_position + new_inc;
  wire [6:0] position_down = base_position - new_inc;
  wire [6:0] next_position = step_down ? position_down : position_up;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      translator_position <= POS_RESET;
      applied_resolution <= RES_1_32;
      step_pulse <= 1'b0;
    end else begin
      step_pulse <= step_now;
      if (step_now) begin
        translator_position <= next_position;
        applied_resolution <= step_resolution_select;
      end
    end
  end

  // ----------------------------------------------------------------
  // step counter, a trigger in the clearing cycle still counts
  // ----------------------------------------------------------------
  wire [15:0] count_inc = step_count + STEPS_ONE;
  wire [15:0] next_step_count = wr_steps ? (step_now ? STEPS_ONE : STEPS_RESET) :
                                (step_now ? count_inc : step_count);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_count <= STEPS_RESET;
    end else begin
      step_count <= next_step_count;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      direction_control_bit <= 1'b0;
      step_edge_polarity_bit <= 1'b0;
      drivers_enable <= 1'b0;
      step_resolution_select <= RES_1_32;
    end else if (wr_ctrl) begin
      direction_control_bit <= apb_req.pwdata[CTRL_DIR_BIT];
      step_edge_polarity_bit <= apb_req.pwdata[CTRL_POL_BIT];
      drivers_enable <= apb_req.pwdata[CTRL_EN_BIT];
      // a new resolution only waits here until the next trigger
      step_resolution_select <= apb_req.pwdata[CTRL_RES_MSB:CTRL_RES_LSB];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      peak_current_setting <= CUR_RESET;
    end else if (wr_current) begin
      peak_current_setting <= apb_req.pwdata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // pwm period and peak current in force
  // ----------------------------------------------------------------
  logic period_tick;
  logic [4:0] active_current;

  stc_pwm_timer #(
    .PERIOD_CYCLES(PWM_CYCLES)
  ) u_pwm_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .period_start(period_tick)
  );

  assign pwm_period_start = period_tick;

  // a mid-period change would distort the running pwm cycle, so it waits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_current <= CUR_RESET;
    end else if (period_tick) begin
      active_current <= peak_current_setting;
    end
  end

  // ----------------------------------------------------------------
  // coil targets
  // ----------------------------------------------------------------
  logic [9:0] x_mag;
  logic [9:0] y_mag;
  logic x_neg;
  logic y_neg;

  stc_sine_lut u_sine_lut (
    .position(translator_position),
    .x_mag(x_mag),
    .x_neg(x_neg),
    .y_mag(y_mag),
    .y_neg(y_neg)
  );

  wire [15:0] x_scaled = stc_scale(x_mag, active_current);
  wire [15:0] y_scaled = stc_scale(y_mag, active_current);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coil_x_target <= '0;
      coil_y_target <= '0;
    end else begin
      coil_x_target <= '{negative: x_neg, magnitude: x_scaled};
      coil_y_target <= '{negative: y_neg, magnitude: y_scaled};
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] ctrl_word;
  logic [31:0] current_word;
  logic [31:0] status_word;
  logic [31:0] coil_x_word;
  logic [31:0] coil_y_word;

  always_comb begin
    ctrl_word = WORD_ZERO;
    ctrl_word[CTRL_DIR_BIT] = direction_control_bit;
    ctrl_word[CTRL_POL_BIT] = step_edge_polarity_bit;
    ctrl_word[CTRL_EN_BIT] = drivers_enable;
    ctrl_word[CTRL_RES_MSB:CTRL_RES_LSB] = step_resolution_select;
  end

  always_comb begin
    current_word = WORD_ZERO;
    current_word[4:0] = peak_current_setting;
  end

  always_comb begin
    status_word = WORD_ZERO;
    status_word[STAT_POS_MSB:STAT_POS_LSB] = translator_position;
    status_word[STAT_DIR_BIT] = step_down;
    status_word[STAT_RES_MSB:STAT_RES_LSB] = applied_resolution;
    status_word[STAT_CUR_MSB:STAT_CUR_LSB] = active_current;
  end

  always_comb begin
    coil_x_word = WORD_ZERO;
    coil_x_word[COIL_MAG_MSB:0] = coil_x_target.magnitude;
    coil_x_word[COIL_NEG_BIT] = coil_x_target.negative;
    coil_y_word = WORD_ZERO;
    coil_y_word[COIL_MAG_MSB:0] = coil_y_target.magnitude;
    coil_y_word[COIL_NEG_BIT] = coil_y_target.negative;
  end

  wire [31:0] read_word = hit_ctrl ? ctrl_word :
                          hit_current ? current_word :
                          hit_status ? status_word :
                          hit_coil_x ? coil_x_word :
                          hit_coil_y ? coil_y_word :
                          hit_steps ? {16'h0000, step_count} : WORD_ZERO;

  // ----------------------------------------------------------------
  // bus response: one wait state, then the access completes
  // ----------------------------------------------------------------
  // the fixed wait state keeps read data a clean flop output
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= first_access;
      if (first_access) begin
        apb_rsp.prdata <= apb_req.pwrite ? WORD_ZERO : read_word;
        apb_rsp.pslverr <= ~mapped;
      end else begin
        apb_rsp.prdata <= WORD_ZERO;
        apb_rsp.pslverr <= 1'b0;
      end
    end
  end

endmodule

// *** sim/stc_translator_sva.sv ***
`timescale 1ns/10ps
module stc_translator_sva
  import stc_pkg::*;
#(
  parameter int PWM_CYCLES = PWM_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire stc_apb_req_t apb_req,
  input wire stc_apb_rsp_t apb_rsp,
  // pins
  input wire logic step_trigger_input,
  input wire logic direction_pin,
  // translator outputs
  input wire logic [6:0] translator_position,
  input wire logic step_pulse,
  input wire logic drivers_enable,
  input wire stc_coil_t coil_x_target,
  input wire stc_coil_t coil_y_target,
  input wire logic pwm_period_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // helpers: shadow of the control word taken from completed writes
  // ----------------------------------------------------------------
  logic [6:0] ctrl;
  logic [6:0] prev_pos;
  logic [6:0] last_inc;
  logic pin_q;
  logic pwm_seen;
  logic [7:0] since_act;
  logic [15:0] pwm_gap;
  wire ctrl_wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == ADDR_CTRL;
  wire act = (pin_q != step_trigger_input) && (step_trigger_input != ctrl[CTRL_POL_BIT]);
  wire [2:0] res = ctrl[CTRL_RES_MSB:CTRL_RES_LSB];
  wire [6:0] inc = (res <= 3'h5) ? (7'h01 << res) : 7'h01;
  wire [6:0] base = (inc < last_inc) ? ((prev_pos + (inc >> 1)) & ~(inc - 7'h01)) : prev_pos;
  wire down = direction_pin ^ ctrl[CTRL_DIR_BIT];
  wire [6:0] exp_pos = down ? base - inc : base + inc;
  wire mapped = apb_req.paddr inside {ADDR_CTRL, ADDR_CURRENT, ADDR_STATUS, ADDR_COIL_X, ADDR_COIL_Y, ADDR_STEPS};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= 7'h00;
      prev_pos <= 7'h00;
      last_inc <= 7'h01;
      pin_q <= 1'b0;
      pwm_seen <= 1'b0;
      since_act <= 8'hff;
      pwm_gap <= 16'h0000;
    end else begin
      if (ctrl_wr) ctrl <= apb_req.pwdata[6:0];
      if (step_pulse) last_inc <= inc;
      if (pwm_period_start) pwm_seen <= 1'b1;
      prev_pos <= translator_position;
      pin_q <= step_trigger_input;
      since_act <= act ? 8'h00 : (since_act == 8'hff ? since_act : since_act + 8'h01);
      pwm_gap <= pwm_period_start ? 16'h0000 : pwm_gap + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_pulse_single: assert property (step_pulse |=> !step_pulse)
    else $error("step pulse wider than one cycle");
  a_pos_on_pulse: assert property ($changed(translator_position) |-> step_pulse)
    else $error("position moved without a step");
  a_edge_steps: assert property (act |-> ##[2:4] step_pulse)
    else $error("active edge gave no step");
  a_step_caused: assert property (step_pulse |-> since_act >= 8'h01 && since_act <= 8'h03)
    else $error("step without an active edge");
  a_step_coarse: assert property (step_pulse && inc >= last_inc |-> translator_position == exp_pos)
    else $error("wrong step amount or direction");
  a_step_finer: assert property (step_pulse && inc < last_inc |-> translator_position == exp_pos)
    else $error("finer step not snapped to grid");
  a_ready_timing: assert property (apb_req.psel && $rose(apb_req.penable) |=> apb_rsp.pready)
    else $error("bus answer late");
  a_err_unmapped: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped)
    else $error("error flag does not match address map");
  a_coil_axis: assert property (prev_pos[4:0] == 5'h00 |->
    (prev_pos[5] ? coil_y_target.magnitude : coil_x_target.magnitude) == 16'h0000)
    else $error("coil not zero on axis");
  a_pwm_period: assert property (pwm_period_start && pwm_seen |-> pwm_gap == PWM_CYCLES - 1)
    else $error("pwm period length wrong");
  a_coil_cause: assert property ($changed(coil_y_target) |-> $past(step_pulse) || $past(step_pulse, 2)
    || $past(pwm_period_start) || $past(pwm_period_start, 2) || $past(sys_rst, 2))
    else $error("coil target changed off period");
  c_finer: cover property (step_pulse && inc < last_inc);
  c_offset: cover property (step_pulse && inc > last_inc && (prev_pos & (inc - 7'h01)) != 7'h00);
  c_slverr: cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule
bind stc_translator stc_translator_sva #(.PWM_CYCLES(PWM_CYCLES)) i_sva (.clk(clk), .sys_rst(sys_rst),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .step_trigger_input(step_trigger_input),
  .direction_pin(direction_pin), .translator_position(translator_position), .step_pulse(step_pulse),
  .drivers_enable(drivers_enable), .coil_x_target(coil_x_target), .coil_y_target(coil_y_target),
  .pwm_period_start(pwm_period_start));

// *** sim/stc_mcu_model.sv ***
`timescale 1ns/10ps
module stc_mcu_model (
  // controller clock
  input wire logic clk,
  // step and direction pins
  output logic step_trigger_input,
  output logic direction_pin
);
  initial begin
    step_trigger_input = 1'b0;
    direction_pin = 1'b0;
  end
  // direction settles before the edge so the synchroniser sees it first;
  // gap sets how promptly the next edge may follow
  task automatic toggle(input logic dir, input int gap);
    direction_pin <= dir;
    repeat (4) @(posedge clk);
    step_trigger_input <= ~step_trigger_input;
    repeat (gap) @(posedge clk);
  endtask
endmodule

// *** sim/tb_stepper_translator_control.sv ***
`timescale 1ns/10ps
module tb_stepper_translator_control;
  import stc_pkg::*;
  localparam int PWM = 12;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  stc_apb_req_t apb_req = '0;
  stc_apb_rsp_t apb_rsp;
  logic step_trigger_input;
  logic direction_pin;
  logic [6:0] translator_position;
  logic step_pulse;
  logic drivers_enable;
  logic pwm_period_start;
  stc_coil_t coil_x_target;
  stc_coil_t coil_y_target;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int m_pos, m_inc, m_ctrl, m_cur, m_steps;
  int seq[$] = '{0, 3, 5, 1, 4, 2, 0, 6, 7, 5, 3};
  logic [7:0] amap[7] = '{ADDR_CTRL, ADDR_CURRENT, ADDR_STATUS, ADDR_COIL_X, ADDR_COIL_Y, ADDR_STEPS, 8'h18};
  always #5 clk = ~clk;
  stc_translator #(.PWM_CYCLES(PWM)) i_dut (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .step_trigger_input(step_trigger_input), .direction_pin(direction_pin),
    .translator_position(translator_position), .step_pulse(step_pulse), .drivers_enable(drivers_enable),
    .coil_x_target(coil_x_target), .coil_y_target(coil_y_target), .pwm_period_start(pwm_period_start));
  stc_mcu_model i_mcu (.clk(clk), .step_trigger_input(step_trigger_input), .direction_pin(direction_pin));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("FAIL %0t run too long", $time);
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  // holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // only the run timeout ends this wait
    do begin
      @(posedge clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    chk(apb_rsp.pready, 1'b1, "bus answer");
    apb_req <= '0;
    @(posedge clk);
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    m_pos = 0;
    m_inc = 1;
    m_ctrl = 0;
    m_cur = 0;
    m_steps = 0;
  endtask
  task automatic step(input logic dir);
    int inc;
    logic act;
    act = (step_trigger_input == 1'b0) ^ m_ctrl[1];
    inc = (m_ctrl[6:4] <= 5) ? 1 << m_ctrl[6:4] : 1;
    i_mcu.toggle(dir, 6 + $urandom_range(0, 6));
    if (act) begin
      if (inc < m_inc) m_pos = (m_pos + inc / 2) & ~(inc - 1);
      m_pos = ((dir ^ m_ctrl[0]) ? m_pos - inc : m_pos + inc) & 127;
      m_inc = inc;
      m_steps++;
    end
    chk(translator_position, m_pos, "position");
  endtask
  task automatic wait_pwm();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pwm_period_start !== 1'b1 && n < 40);
    chk(pwm_period_start, 1'b1, "pwm tick");
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h666f_829a));
    do_reset();
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    foreach (amap[k]) begin
      apb(1'b0, amap[k], 32'h0000_0000);
      chk(rd, (amap[k] == ADDR_COIL_Y) ? 32'd1000 : 32'h0000_0000, "reset value");
      chk(er, k == 6, "error flag");
    end
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      m_ctrl = $urandom_range(0, 7);
      apb(1'b1, ADDR_CTRL, m_ctrl);
      chk(drivers_enable, m_ctrl[2], "enable");
      repeat (2) step($urandom_range(0, 1));
    end
    $display("test edges done");
    m_ctrl = 0;
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    while (m_pos % 8 != 0) step(1'b0);
    foreach (seq[k]) begin
      m_ctrl = seq[k] << 4;
      apb(1'b1, ADDR_CTRL, m_ctrl);
      chk(translator_position, m_pos, "hold");
      repeat (3) step($urandom_range(0, 1));
    end
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd[6:0], m_pos, "status position");
    apb(1'b0, ADDR_STEPS, 32'h0000_0000);
    chk(rd, m_steps, "step count");
    apb(1'b1, ADDR_STEPS, 32'hffff_ffff);
    m_steps = 0;
    apb(1'b0, ADDR_STEPS, 32'h0000_0000);
    chk(rd, m_steps, "step count cleared");
    $display("test resolution done");
    if (step_trigger_input) step(1'b0);
    do_reset();
    for (int c = 0; c < 3; c++) begin
      int old;
      old = m_cur;
      m_cur = (c == 0) ? 31 : $urandom_range(0, 30);
      wait_pwm();
      apb(1'b1, ADDR_CURRENT, m_cur);
      chk(coil_y_target.magnitude, 1000 * (old + 1), "coil before tick");
      wait_pwm();
      repeat (3) @(posedge clk);
      chk(coil_y_target.magnitude, 1000 * (m_cur + 1), "coil after tick");
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk(rd[20:16], m_cur, "status current");
    end
    m_ctrl = RES_FULL << 4;
    apb(1'b1, ADDR_CTRL, m_ctrl);
    step(1'b0);
    chk(coil_x_target, {1'b0, 16'(1000 * (m_cur + 1))}, "coil x at 32");
    repeat (2) step(1'b0);
    chk(coil_y_target, {1'b1, 16'(1000 * (m_cur + 1))}, "coil y at 64");
    $display("test current done");
    close_out();
  end
endmodule
